// ==== hwp_write_cycle.sv ====
// target-side single-byte write cycle engine with hardware write protect
`include "hwp_defs.svh"

// Behaviour
// - write starts on nibble 1110b with strobe low; last start before release counts
// - clock two select nibble must equal the strapped select inputs to participate
// - clocks three to nine carry 28 address bits, most significant nibble first
// - clock ten size nibble 0000b means one byte; only single bytes supported
// - data low nibble in clock 11, high nibble in clock 12
// - device takes bus in clock 14 and drives ready 0000 in clock 15
// - device drives 1111b in clock 16 then floats; host resumes in 17
// - each nibble is sampled on the rising edge of its own clock
// - lines stay high impedance whenever the device is not selected
// - only the lowest 20 address bits and bit 22 are decoded; other upper bits ignored
// - address bit 22 high selects flash array, low selects register space
// - bad size nibble resets the machine, no operation, no response
// - after valid start, select and size, all later inputs are taken as valid
// - strobe low mid-cycle releases the lines and resets the machine
// - abort never stops a program or erase already running
// - nothing starts before the last data nibble; abort by clock 12 is harmless
// - top protect input low blocks program and erase of sector 15
// - general protect input blocks the lower fifteen sectors, independent of top
// - protect inputs are sampled when a program or erase starts
// - protect changes during suspend take effect only after the operation completes
// - active protect blocks writes despite clear write lock; read lock still works
module hwp_write_cycle
  import hwp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  bus_nibble_in,
  output wire logic [3:0]  bus_nibble_out,
  output wire logic        bus_nibble_oe_n,
  input  wire logic        frame_strobe_n,
  input  wire logic [3:0]  select_straps,
  input  wire logic        top_sector_protect_n,
  input  wire logic        gen_sector_protect_n,
  input  wire logic        core_busy,
  input  wire logic        core_suspend,
  output wire logic        core_wr,
  output wire logic [19:0] core_addr,
  output wire logic [7:0]  core_data,
  output wire logic        core_protect,
  output wire logic [15:0] sector_read_lock
);

  localparam hwp_main_t MAIN_RESET = '{
    st:           HWP_ST_IDLE,
    cnt:          3'h0,
    addr:         28'h000_0000,
    dlo:          4'h0,
    bus_out:      `HWP_NIB_TAR_ONES,
    bus_oe_n:     1'b1,
    core_wr:      1'b0,
    core_addr:    20'h0_0000,
    core_data:    8'h00,
    core_protect: 1'b0,
    lock_wr:      1'b0,
    lock_sector:  4'h0,
    lock_data:    3'h0,
    top_sync:     `HWP_PIN_SYNC_RESET,
    gen_sync:     `HWP_PIN_SYNC_RESET,
    strap_s1:     `HWP_STRAP_RESET,
    strap_s2:     `HWP_STRAP_RESET,
    top_act:      1'b1,
    gen_act:      1'b1
  };

  hwp_main_t   q;
  hwp_main_t   d;
  hwp_lock_if  lk ();

  function automatic logic [3:0] sector_of(input logic [27:0] a);
    sector_of = a[`HWP_SECTOR_MSB:`HWP_SECTOR_LSB];
  endfunction

  // pick the protect pin that covers the sector
  function automatic logic pin_blocks(input logic [3:0] sec,
                                      input logic       top_on,
                                      input logic       gen_on);
    if (sec == `HWP_TOP_SECTOR)
    begin
      pin_blocks = top_on;
    end
    else
    begin
      pin_blocks = gen_on;
    end
  endfunction

  // a pin blocks its sectors even when the write lock is clear; the lock still counts alone
  function automatic logic protect_of(input logic [3:0] sec,
                                      input logic       top_on,
                                      input logic       gen_on,
                                      input logic       wl);
    protect_of = pin_blocks(sec, top_on, gen_on) | wl;
  endfunction

  // one address bit splits array space from register space
  function automatic logic flash_space(input logic [27:0] a);
    flash_space = a[`HWP_SPACE_BIT];
  endfunction

  function automatic logic lock_reg_hit(input logic [27:0] a);
    lock_reg_hit = (a[`HWP_LOCK_OFS_MSB:0] == `HWP_LOCK_REG_OFS);
  endfunction

  // only a write start nibble opens a cycle; anything else parks the machine
  function automatic hwp_state_t restart_state(input logic [3:0] nib);
    if (nib == `HWP_NIB_START_WRITE)
    begin
      restart_state = HWP_ST_START;
    end
    else
    begin
      restart_state = HWP_ST_IDLE;
    end
  endfunction

  // most significant nibble arrives first, so shift left and append
  function automatic logic [27:0] next_addr(input logic [27:0] a,
                                            input logic [3:0]  nib);
    next_addr = {a[23:0], nib};
  endfunction

  function automatic logic [7:0] byte_of(input logic [3:0] hi,
                                         input logic [3:0] lo);
    byte_of = {hi, lo};
  endfunction

  // synchroniser step: callers read only bit 1, never the first stage
  function automatic logic [1:0] sync_step(input logic [1:0] s,
                                           input logic       pin);
    sync_step = {s[0], pin};
  endfunction

  function automatic logic pin_active(input logic [1:0] s);
    pin_active = ~s[1];
  endfunction

  // cycle walk, by the rising edge that samples each field:
  //   1 start, 2 select, 3-9 address, 10 size, 11-12 data low then high
  //   13-14 host turnaround, the lines come to us after 14
  //   after 14 we drive ready, after 15 ones, after 16 we let go
  // the byte leaves for the array one clock after edge 12 and never earlier,
  // so an abort up to edge 12 costs nothing; the release after an abort
  // is one clock late because every output comes from a flop
  always_comb
  begin
    d = q;
    d.core_wr = 1'b0;
    d.lock_wr = 1'b0;

    // protect pins and straps are asynchronous: two flops before use
    d.top_sync = sync_step(q.top_sync, top_sector_protect_n);
    d.gen_sync = sync_step(q.gen_sync, gen_sector_protect_n);
    d.strap_s1 = select_straps;
    d.strap_s2 = q.strap_s1;

    // track pins only while the array is idle; frozen across busy and suspend
    if (!core_busy && !core_suspend)
    begin
      d.top_act = pin_active(q.top_sync);
      d.gen_act = pin_active(q.gen_sync);
    end

    if (!frame_strobe_n)
    begin
      // strobe low always restarts; a later start nibble replaces an earlier one
      d.bus_oe_n = 1'b1;
      d.bus_out  = `HWP_NIB_TAR_ONES;
      d.cnt      = 3'h0;
      d.st       = restart_state(bus_nibble_in);
    end
    else
    begin
      case (q.st)
        HWP_ST_IDLE:
        begin
          d.bus_oe_n = 1'b1;
        end
        HWP_ST_START:
        begin
          if (bus_nibble_in == q.strap_s2)
          begin
            d.st  = HWP_ST_ADDR;
            d.cnt = 3'h0;
          end
          else
          begin
            d.st = HWP_ST_IDLE;
          end
        end
        HWP_ST_ADDR:
        begin
          d.addr = next_addr(q.addr, bus_nibble_in);
          if (q.cnt == `HWP_ADDR_LAST_NIB)
          begin
            d.st = HWP_ST_SIZE;
          end
          else
          begin
            d.cnt = q.cnt + 3'h1;
          end
        end
        HWP_ST_SIZE:
        begin
          if (bus_nibble_in == `HWP_NIB_SIZE_ONE)
          begin
            d.st = HWP_ST_DLO;
          end
          else
          begin
            d.st = HWP_ST_IDLE;
          end
        end
        HWP_ST_DLO:
        begin
          d.dlo = bus_nibble_in;
          d.st  = HWP_ST_DHI;
        end
        HWP_ST_DHI:
        begin
          // last nibble in: only now may anything reach the array or the locks
          d.st = HWP_ST_TAR0;
          if (flash_space(q.addr))
          begin
            d.core_wr      = 1'b1;
            d.core_addr    = q.addr[`HWP_DECODE_MSB:0];
            d.core_data    = byte_of(bus_nibble_in, q.dlo);
            d.core_protect = protect_of(sector_of(q.addr), q.top_act, q.gen_act,
                                        lk.wlock[sector_of(q.addr)]);
          end
          else if (lock_reg_hit(q.addr))
          begin
            d.lock_wr     = 1'b1;
            d.lock_sector = sector_of(q.addr);
            d.lock_data   = q.dlo[2:0];
          end
        end
        HWP_ST_TAR0:
        begin
          // host owns the lines with 1111b here; nothing to sample
          d.st = HWP_ST_TAR1;
        end
        HWP_ST_TAR1:
        begin
          d.bus_oe_n = 1'b0;
          d.bus_out  = `HWP_NIB_SYNC_READY;
          d.st       = HWP_ST_SYNC;
        end
        HWP_ST_SYNC:
        begin
          d.bus_out = `HWP_NIB_TAR_ONES;
          d.st      = HWP_ST_RTAR;
        end
        HWP_ST_RTAR:
        begin
          d.bus_oe_n = 1'b1;
          d.st       = HWP_ST_IDLE;
        end
        default:
        begin
          d.bus_oe_n = 1'b1;
          d.st       = HWP_ST_IDLE;
        end
      endcase
    end
  end

  // sampling on the rising edge of each field's own clock
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      q <= MAIN_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign lk.lock_wr     = q.lock_wr;
  assign lk.lock_sector = q.lock_sector;
  assign lk.lock_data   = q.lock_data;

  hwp_lock_regs u_lock (
    .clock (clock),
    .rst   (rst),
    .lk    (lk.regs)
  );

  // abort has no path to the array: a running program or erase carries on
  assign core_wr          = q.core_wr;
  assign core_addr        = q.core_addr;
  assign core_data        = q.core_data;
  assign core_protect     = q.core_protect;
  assign bus_nibble_out   = q.bus_out;
  assign bus_nibble_oe_n  = q.bus_oe_n;
  assign sector_read_lock = lk.rlock;

endmodule

// ==== hwp_defs.svh ====
// constants for the write-cycle and hardware-protect block
`ifndef HWP_DEFS_SVH
`define HWP_DEFS_SVH

`define HWP_NIB_START_WRITE 4'hE
`define HWP_NIB_SIZE_ONE    4'h0
`define HWP_NIB_SYNC_READY  4'h0
`define HWP_NIB_TAR_ONES    4'hF

`define HWP_ADDR_W          28
`define HWP_ADDR_LAST_NIB   3'h6
`define HWP_DECODE_MSB      19
`define HWP_SPACE_BIT       22
`define HWP_SECTOR_MSB      19
`define HWP_SECTOR_LSB      16
`define HWP_TOP_SECTOR      4'hF
`define HWP_LOCK_REG_OFS    16'h0002
`define HWP_LOCK_OFS_MSB    15

`define HWP_LR_WLOCK        0
`define HWP_LR_LOCKDOWN     1
`define HWP_LR_RLOCK        2
`define HWP_LR_RESET        3'h1
`define HWP_NUM_SECTORS     16

`define HWP_STRAP_RESET     4'h0
`define HWP_PIN_SYNC_RESET  2'h3

`endif

// ==== hwp_pkg.sv ====
// types shared by the write-cycle and lock register modules
package hwp_pkg;

  typedef enum logic [9:0] {
    HWP_ST_IDLE  = 10'b00_0000_0001,
    HWP_ST_START = 10'b00_0000_0010,
    HWP_ST_ADDR  = 10'b00_0000_0100,
    HWP_ST_SIZE  = 10'b00_0000_1000,
    HWP_ST_DLO   = 10'b00_0001_0000,
    HWP_ST_DHI   = 10'b00_0010_0000,
    HWP_ST_TAR0  = 10'b00_0100_0000,
    HWP_ST_TAR1  = 10'b00_1000_0000,
    HWP_ST_SYNC  = 10'b01_0000_0000,
    HWP_ST_RTAR  = 10'b10_0000_0000
  } hwp_state_t;

  typedef struct packed {
    hwp_state_t  st;
    logic [2:0]  cnt;
    logic [27:0] addr;
    logic [3:0]  dlo;
    logic [3:0]  bus_out;
    logic        bus_oe_n;
    logic        core_wr;
    logic [19:0] core_addr;
    logic [7:0]  core_data;
    logic        core_protect;
    logic        lock_wr;
    logic [3:0]  lock_sector;
    logic [2:0]  lock_data;
    logic [1:0]  top_sync;
    logic [1:0]  gen_sync;
    logic [3:0]  strap_s1;
    logic [3:0]  strap_s2;
    logic        top_act;
    logic        gen_act;
  } hwp_main_t;

  typedef struct packed {
    logic [15:0][2:0] lock;
  } hwp_lock_t;

endpackage

// ==== hwp_lock_if.sv ====
// carrier between the cycle engine and the sector lock registers
interface hwp_lock_if;
  logic        lock_wr;
  logic [3:0]  lock_sector;
  logic [2:0]  lock_data;
  logic [15:0] wlock;
  logic [15:0] rlock;

  modport engine (
    output lock_wr,
    output lock_sector,
    output lock_data,
    input  wlock,
    input  rlock
  );

  modport regs (
    input  lock_wr,
    input  lock_sector,
    input  lock_data,
    output wlock,
    output rlock
  );
endinterface

// ==== hwp_lock_regs.sv ====
// sector lock registers: write lock, lock-down and read lock per sector
`include "hwp_defs.svh"

module hwp_lock_regs
  import hwp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  hwp_lock_if.regs lk
);

  hwp_lock_t q;
  hwp_lock_t d;

  always_comb
  begin
    d = q;
    // lock-down freezes the whole entry until reset
    if (lk.lock_wr && !q.lock[lk.lock_sector][`HWP_LR_LOCKDOWN])
    begin
      d.lock[lk.lock_sector] = lk.lock_data;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      q <= '{lock: {`HWP_NUM_SECTORS{`HWP_LR_RESET}}};
    end
    else
    begin
      q <= d;
    end
  end

  genvar i;
  generate
    for (i = 0; i < `HWP_NUM_SECTORS; i++)
    begin : g_bits
      assign lk.wlock[i] = q.lock[i][`HWP_LR_WLOCK];
      assign lk.rlock[i] = q.lock[i][`HWP_LR_RLOCK];
    end
  endgenerate

endmodule

// ==== hwp_write_cycle_props.sv ====
// assertions on the write-cycle engine ports
module hwp_write_cycle_props
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [3:0]  bus_nibble_in,
  input wire logic [3:0]  bus_nibble_out,
  input wire logic        bus_nibble_oe_n,
  input wire logic        frame_strobe_n,
  input wire logic        core_wr,
  input wire logic [19:0] core_addr,
  input wire logic [7:0]  core_data
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  chk_start_nibble: assert property (core_wr |-> !$past(frame_strobe_n, 12)
    && $past(bus_nibble_in, 12) == 4'hE) else $error("write without start");
  chk_size_one: assert property (core_wr |-> $past(bus_nibble_in, 3) == 4'h0)
    else $error("write after bad size");
  chk_data_order: assert property (core_wr |-> core_data ==
    {$past(bus_nibble_in, 1), $past(bus_nibble_in, 2)}) else $error("data order");
  chk_addr_nibbles: assert property (core_wr |-> core_addr[3:0] ==
    $past(bus_nibble_in, 4) && core_addr[19:16] == $past(bus_nibble_in, 8))
    else $error("address order");
  chk_no_abort: assert property (core_wr |-> $past(frame_strobe_n, 1)
    && $past(frame_strobe_n, 11)) else $error("write after abort");
  chk_ready_sync: assert property (core_wr && frame_strobe_n ##1 frame_strobe_n
    |=> !bus_nibble_oe_n && bus_nibble_out == 4'h0) else $error("no ready sync");
  chk_tar_ones: assert property ($fell(bus_nibble_oe_n) ##1 !bus_nibble_oe_n
    |-> bus_nibble_out == 4'hF) else $error("turnaround value");
  chk_drive_len: assert property (!bus_nibble_oe_n [*2] |=> bus_nibble_oe_n)
    else $error("drive too long");
  chk_abort_float: assert property (!frame_strobe_n |=> bus_nibble_oe_n)
    else $error("no release on abort");
endmodule
bind hwp_write_cycle hwp_write_cycle_props u_hwp_write_cycle_props (.clock(clock),
  .rst(rst), .bus_nibble_in(bus_nibble_in), .bus_nibble_out(bus_nibble_out),
  .bus_nibble_oe_n(bus_nibble_oe_n), .frame_strobe_n(frame_strobe_n),
  .core_wr(core_wr), .core_addr(core_addr), .core_data(core_data));

// ==== hwp_host_model.sv ====
// host bus controller model issuing write cycles
module hwp_host_model
(
  input  wire logic [3:0] bus_lines,
  input  wire logic       clock,
  output logic      [3:0] host_val,
  output logic            frame_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    host_val = 4'hF;
    frame_strobe_n = 1'b1;
  end
  // ab names the clock that carries a strobe abort, 0 for none
  task automatic cycle(input logic [3:0] sel, input logic [27:0] a,
    input logic [3:0] sz, input logic [7:0] d, input int ab,
    output logic [3:0] rs, output logic [3:0] t16);
    rs = 4'h1;
    t16 = 4'h1;
    @(negedge clock);
    frame_strobe_n = 1'b0;
    host_val = 4'hD;
    for (int k = 1; k <= 17; k++)
    begin
      @(negedge clock);
      if (k == 15) rs = bus_lines;
      if (k == 16) t16 = bus_lines;
      case (k)
        1: host_val = 4'hE;
        2: host_val = sel;
        10: host_val = sz;
        11: host_val = d[3:0];
        12: host_val = d[7:4];
        13: host_val = 4'hF;
        // released lines toggle from 1111b, so undriven they read 0000b at the ready sample and 1111b at the next
        default: host_val = (k <= 9) ? a[4*(9-k) +: 4] : ~host_val;
      endcase
      frame_strobe_n = !(k == 1 || k == ab);
      if (k == ab) host_val = 4'h0;
      if (k == ab) break;
    end
    @(negedge clock);
    frame_strobe_n = 1'b1;
    host_val = ~host_val;
  endtask
endmodule

// ==== hwp_write_cycle_tb_top.sv ====
// testbench for the write-cycle engine
module hwp_write_cycle_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        top_n = 1'b1;
  logic        gen_n = 1'b1;
  logic        busy = 1'b0;
  logic        susp = 1'b0;
  logic [3:0]  straps = 4'h5;
  logic [3:0]  host_val;
  logic        strobe_n;
  logic [3:0]  dev_out;
  logic        dev_oe_n;
  logic        wr;
  logic [19:0] w_addr;
  logic [7:0]  w_data;
  logic        w_prot;
  logic        s_prot;
  logic [15:0] rlock;
  logic [3:0]  rs;
  logic [3:0]  t16;
  wire  [3:0]  bus_lines = (dev_oe_n === 1'b0) ? dev_out : host_val;
  int          fail_count = 0;
  int          num_checks = 0;
  int          n_wr = 0;
  int          n_oe = 0;
  int          cyc = 0;
  hwp_write_cycle u_hwp_write_cycle (.clock(clock), .rst(rst), .bus_nibble_in(bus_lines),
    .bus_nibble_out(dev_out), .bus_nibble_oe_n(dev_oe_n), .frame_strobe_n(strobe_n),
    .select_straps(straps), .top_sector_protect_n(top_n), .gen_sector_protect_n(gen_n),
    .core_busy(busy), .core_suspend(susp), .core_wr(wr), .core_addr(w_addr),
    .core_data(w_data), .core_protect(w_prot), .sector_read_lock(rlock));
  hwp_host_model u_hwp_host_model (.bus_lines(bus_lines), .clock(clock),
    .host_val(host_val), .frame_strobe_n(strobe_n));
  always #12.5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    if (wr === 1'b1) n_wr++;
    if (wr === 1'b1) s_prot = w_prot;
    if (dev_oe_n === 1'b0) n_oe++;
    if (cyc == 20000) fail_count++;
    if (cyc == 20000) wrap_up();
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [27:0] e, input logic [27:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic wr_cyc(input logic [3:0] sel, input logic [27:0] a, input logic [7:0] d,
    input logic [3:0] sz, input int ab);
    u_hwp_host_model.cycle(sel, a, sz, d, ab, rs, t16);
    repeat (4) @(negedge clock);
  endtask
  task automatic t_lock();
    int w0;
    w0 = n_wr;
    wr_cyc(4'h5, 28'hAB3_0002, 8'h00, 4'h0, 0);
    chk("ready", 28'h0, 28'(rs));
    chk("tar", 28'hF, 28'(t16));
    wr_cyc(4'h5, 28'hABF_0002, 8'h00, 4'h0, 0);
    wr_cyc(4'h5, 28'hAB3_0002, 8'h04, 4'h0, 0);
    // sector 5 locked down open: the later read-lock request must be ignored
    wr_cyc(4'h5, 28'hAB5_0002, 8'h02, 4'h0, 0);
    wr_cyc(4'h5, 28'hAB5_0002, 8'h04, 4'h0, 0);
    chk("rlock", 28'h8, 28'(rlock));
    chk("reg wr", 28'h0, 28'(n_wr - w0));
    $display("t_lock done");
  endtask
  task automatic t_flash();
    logic [1:0] pins [4] = '{2'b11, 2'b10, 2'b01, 2'b01};
    logic [3:0] sec [4] = '{4'h3, 4'h3, 4'h3, 4'hF};
    logic       prot [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    int         w0;
    for (int i = 0; i < 4; i++)
    begin
      {top_n, gen_n} = pins[i];
      repeat (6) @(negedge clock);
      w0 = n_wr;
      wr_cyc(4'h5, {8'hF4, sec[i], 16'h1234}, 8'hA5, 4'h0, 0);
      chk("wr", 28'h1, 28'(n_wr - w0));
      chk("addr", 28'({sec[i], 16'h1234}), 28'(w_addr));
      chk("data", 28'hA5, 28'(w_data));
      chk("prot", 28'(prot[i]), 28'(s_prot));
    end
    {top_n, gen_n} = 2'b11;
    $display("t_flash done");
  endtask
  task automatic t_refuse();
    logic [3:0] sel [4] = '{4'h6, 4'h5, 4'h5, 4'h5};
    logic [3:0] sz [4] = '{4'h0, 4'h1, 4'h0, 4'h0};
    int         ab [4] = '{0, 0, 12, 15};
    int         w0;
    int         o0;
    for (int i = 0; i < 4; i++)
    begin
      w0 = n_wr;
      o0 = n_oe;
      wr_cyc(sel[i], 28'hF43_1234, 8'h5A, sz[i], ab[i]);
      chk("wr", 28'(i / 3), 28'(n_wr - w0));
      chk("drive", 28'(i / 3), 28'(n_oe - o0));
    end
    straps = 4'hA;
    repeat (4) @(negedge clock);
    w0 = n_wr;
    wr_cyc(4'hA, 28'hF43_1234, 8'h5A, 4'h0, 0);
    chk("strap wr", 28'h1, 28'(n_wr - w0));
    straps = 4'h5;
    repeat (4) @(negedge clock);
    $display("t_refuse done");
  endtask
  task automatic t_freeze();
    busy = 1'b1;
    gen_n = 1'b0;
    repeat (6) @(negedge clock);
    wr_cyc(4'h5, 28'hF43_1234, 8'h11, 4'h0, 0);
    chk("busy prot", 28'h0, 28'(s_prot));
    busy = 1'b0;
    susp = 1'b1;
    wr_cyc(4'h5, 28'hF43_1234, 8'h22, 4'h0, 0);
    chk("susp prot", 28'h0, 28'(s_prot));
    susp = 1'b0;
    repeat (6) @(negedge clock);
    wr_cyc(4'h5, 28'hF43_1234, 8'h33, 4'h0, 0);
    chk("idle prot", 28'h1, 28'(s_prot));
    gen_n = 1'b1;
    $display("t_freeze done");
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    t_lock();
    t_flash();
    t_refuse();
    t_freeze();
    wrap_up();
  end
endmodule
